// >>> ugs_top.sv
`timescale 1ns/1ns
module ugs_top
    import ugs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt
    output logic             irq_o,
    // Downstream port pins (two ports)
    input  wire logic [1:0]  conn_i,
    input  wire logic [1:0]  dp_i,
    input  wire logic [1:0]  dm_i,
    output logic      [1:0]  dp_o,
    output logic      [1:0]  dm_o,
    output logic      [1:0]  oe_n_o,
    // Schedule engine
    input  wire logic        txn_busy_i,
    input  wire logic        txn_done_i,
    output logic             sched_en_o,
    output logic             sof_en_o
);

    // ------------------------------------------------------------------------
    // Whole module state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic                run_stop;    // Schedule run request
        logic                step_debug;  // Single transaction stepping
        logic                susp_req;    // Global suspend request
        logic                force_res;   // Force resume flag as read back
        logic [UGS_EV_W-1:0] istat;       // Sticky events
        logic [UGS_EV_W-1:0] imask;       // Event enables
        ugs_state_t          st;          // Port signalling state
        logic [7:0]          cnt;         // EOP phase timer
        logic [1:0]          conn_prev;   // Connect level last cycle
        logic                ack;         // Bus answer
        logic [31:0]         dat;         // Read data
        logic                irq;         // Interrupt level
        logic [1:0]          dp;          // Driven D+ level
        logic [1:0]          dm;          // Driven D- level
        logic [1:0]          oe_n;        // Low while driving
        logic                sched_en;    // Schedule may issue transactions
        logic                sof_en;      // Frame start packets allowed
        logic                halted;      // Stopped state reached
    } ugs_regs_t;

    ugs_regs_t s_q;   // Registered state
    ugs_regs_t s_d;   // Next state

    logic [1:0] conn_s;   // Synchronised connect levels
    logic [1:0] dp_s;     // Synchronised D+
    logic [1:0] dm_s;     // Synchronised D-

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    ugs_sync #(
        .W (6)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({conn_i, dp_i, dm_i}),
        .q_o   ({conn_s, dp_s, dm_s})
    );

    // K state on any port: D+ low, D- high
    function automatic logic any_k(input logic [1:0] p, input logic [1:0] m);
        any_k = |(~p & m);
    endfunction

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    logic                wr;       // Write takes effect this edge
    logic                rd_hit;   // New request, read or write, being answered
    logic [UGS_EV_W-1:0] ev;       // Events raised this cycle
    logic                res_ev;   // Resume event on the bus
    logic                fr_clr;   // Software clears force resume
    logic                fr_set;   // Software sets force resume
    logic [7:0]          cmd_wd;   // Written command byte

    always_comb begin
        s_d    = s_q;
        ev     = '0;
        cmd_wd = wb_dat_i[7:0];
        // Write lands at the edge where the master sees ack
        wr     = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack && wb_sel_i[0];
        rd_hit = wb_cyc_i && wb_stb_i && !s_q.ack;
        fr_clr = wr && (wb_adr_i == UGS_CMD_OFF) && !cmd_wd[UGS_CMD_FORCE_RES];
        fr_set = wr && (wb_adr_i == UGS_CMD_OFF) && cmd_wd[UGS_CMD_FORCE_RES];

        // Connect change or K on any port, whether the ports are driven or not
        res_ev = (s_q.conn_prev != conn_s) || any_k(dp_s, dm_s);
        s_d.conn_prev = conn_s;

        // Bus answer: one wait state, ack dropped after one cycle
        s_d.ack = rd_hit;

        // Command writes; force resume is owned by the port state machine
        if (wr && wb_adr_i == UGS_CMD_OFF) begin
            s_d.run_stop   = cmd_wd[UGS_CMD_RUN_STOP];
            s_d.step_debug = cmd_wd[UGS_CMD_STEP_DEBUG];
            s_d.susp_req   = cmd_wd[UGS_CMD_SUSPEND];
        end
        if (wr && wb_adr_i == UGS_IMASK_OFF) begin
            s_d.imask = wb_dat_i[UGS_EV_W-1:0];
        end

        // Stepping: drop run/stop after every finished transaction
        if (s_q.step_debug && txn_done_i && s_q.run_stop) begin
            s_d.run_stop = 1'b0;
        end

        // Stopped once run/stop is low and the current transaction ended
        s_d.halted = !s_d.run_stop && !txn_busy_i;
        if (s_d.halted && !s_q.halted) begin
            ev[UGS_EV_HALTED] = 1'b1;
        end

        // Port signalling
        unique case (s_q.st)
            UGS_IDLE: begin
                if (fr_set) begin
                    s_d.st        = UGS_RESUME;
                    s_d.force_res = 1'b1;
                end else if (s_d.susp_req) begin
                    s_d.st = UGS_SUSP;
                end
            end
            UGS_SUSP: begin
                if (fr_set) begin
                    s_d.st        = UGS_RESUME;
                    s_d.force_res = 1'b1;
                end else if (res_ev) begin
                    // Hardware sets the flag; a same-cycle write cannot lose it
                    s_d.st                = UGS_RESUME;
                    s_d.force_res         = 1'b1;
                    ev[UGS_EV_RESUME]     = 1'b1;
                end else if (!s_d.susp_req) begin
                    s_d.st = UGS_IDLE;
                end
            end
            UGS_RESUME: begin
                // Length of resume is timed by software, not here
                if (fr_clr) begin
                    s_d.st  = UGS_EOP_SE0;
                    s_d.cnt = 8'(UGS_SE0_CYC - 1);
                end
            end
            UGS_EOP_SE0: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.st  = UGS_EOP_J;
                    s_d.cnt = 8'(UGS_J_CYC - 1);
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            UGS_EOP_J: begin
                if (s_q.cnt == 8'h00) begin
                    // Flag drops only now that the EOP is complete
                    s_d.force_res         = 1'b0;
                    ev[UGS_EV_EOP_DONE]   = 1'b1;
                    s_d.st = s_d.susp_req ? UGS_SUSP : UGS_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            default: begin
                s_d.st = UGS_IDLE;
            end
        endcase

        // Pin drive for the next state
        unique case (s_d.st)
            UGS_RESUME: begin
                s_d.dp   = 2'h0;
                s_d.dm   = 2'h3;
                s_d.oe_n = 2'h0;
            end
            UGS_EOP_SE0: begin
                s_d.dp   = 2'h0;
                s_d.dm   = 2'h0;
                s_d.oe_n = 2'h0;
            end
            UGS_EOP_J: begin
                s_d.dp   = 2'h3;
                s_d.dm   = 2'h0;
                s_d.oe_n = 2'h0;
            end
            default: begin
                // Released: idle level comes from the line pull resistors
                s_d.dp   = 2'h0;
                s_d.dm   = 2'h0;
                s_d.oe_n = UGS_OE_N_RST;
            end
        endcase

        // No traffic or frame starts unless running and not suspended/resuming
        s_d.sched_en = s_d.run_stop && (s_d.st == UGS_IDLE) && !s_d.susp_req;
        s_d.sof_en   = s_d.sched_en;

        // Sticky events: set wins over a write-one clear
        if (wr && wb_adr_i == UGS_ISTAT_OFF) begin
            s_d.istat = s_q.istat & ~wb_dat_i[UGS_EV_W-1:0];
        end
        s_d.istat = s_d.istat | ev;
        s_d.irq   = |(s_d.istat & s_d.imask);

        // Read data, unmapped offsets read zero
        s_d.dat = 32'h0000_0000;
        if (rd_hit && !wb_we_i) begin
            unique case (wb_adr_i)
                UGS_CMD_OFF: begin
                    s_d.dat[UGS_CMD_RUN_STOP]   = s_q.run_stop;
                    s_d.dat[UGS_CMD_SUSPEND]    = s_q.susp_req;
                    s_d.dat[UGS_CMD_FORCE_RES]  = s_q.force_res;
                    s_d.dat[UGS_CMD_STEP_DEBUG] = s_q.step_debug;
                end
                UGS_STS_OFF: begin
                    s_d.dat[UGS_STS_HALTED]     = s_q.halted;
                    s_d.dat[UGS_STS_SUSPENDED]  = (s_q.st == UGS_SUSP);
                    s_d.dat[UGS_STS_SIGNALLING] = !s_q.oe_n[0];
                end
                UGS_ISTAT_OFF: begin
                    s_d.dat[UGS_EV_W-1:0] = s_q.istat;
                end
                UGS_IMASK_OFF: begin
                    s_d.dat[UGS_EV_W-1:0] = s_q.imask;
                end
                default: begin
                    s_d.dat = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q        <= '0;
            s_q.oe_n   <= UGS_OE_N_RST;
            s_q.halted <= UGS_HALT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs straight from the state register
    // ------------------------------------------------------------------------
    assign wb_dat_o   = s_q.dat;
    assign wb_ack_o   = s_q.ack;
    assign irq_o      = s_q.irq;
    assign dp_o       = s_q.dp;
    assign dm_o       = s_q.dm;
    assign oe_n_o     = s_q.oe_n;
    assign sched_en_o = s_q.sched_en;
    assign sof_en_o   = s_q.sof_en;
endmodule

// >>> ugs_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the global suspend/resume block
// ----------------------------------------------------------------------------
package ugs_pkg;

    // ------------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------------
    localparam logic [7:0] UGS_CMD_OFF   = 8'h00; // Command bits
    localparam logic [7:0] UGS_STS_OFF   = 8'h04; // Live state, read only
    localparam logic [7:0] UGS_ISTAT_OFF = 8'h08; // Sticky events, write 1 to clear
    localparam logic [7:0] UGS_IMASK_OFF = 8'h0c; // Event enables

    // ------------------------------------------------------------------------
    // Command register bit positions
    // ------------------------------------------------------------------------
    localparam int UGS_CMD_RUN_STOP   = 0;
    localparam int UGS_CMD_SUSPEND    = 3;
    localparam int UGS_CMD_FORCE_RES  = 4;
    localparam int UGS_CMD_STEP_DEBUG = 5;

    // ------------------------------------------------------------------------
    // Status register bit positions
    // ------------------------------------------------------------------------
    localparam int UGS_STS_HALTED     = 0;
    localparam int UGS_STS_SUSPENDED  = 1;
    localparam int UGS_STS_SIGNALLING = 2;

    // ------------------------------------------------------------------------
    // Event bit positions (interrupt status and mask share the layout)
    // ------------------------------------------------------------------------
    localparam int UGS_EV_RESUME   = 0; // Resume seen while suspended
    localparam int UGS_EV_EOP_DONE = 1; // Terminating EOP finished
    localparam int UGS_EV_HALTED   = 2; // Controller entered stopped state
    localparam int UGS_EV_W        = 3;

    // ------------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------------
    localparam logic [1:0] UGS_OE_N_RST = 2'h3; // Ports released
    localparam logic       UGS_HALT_RST = 1'h1; // Stopped out of reset

    // ------------------------------------------------------------------------
    // Timing: low-speed EOP is two bit times of SE0 then one of J
    // ------------------------------------------------------------------------
    localparam int UGS_CLK_MHZ    = 125;
    localparam int UGS_EOP_SE0_NS = 1334;
    localparam int UGS_EOP_J_NS   = 667;
    localparam int UGS_SE0_CYC    = (UGS_EOP_SE0_NS * UGS_CLK_MHZ + 999) / 1000;
    localparam int UGS_J_CYC      = (UGS_EOP_J_NS * UGS_CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------------
    // Port signalling state machine
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        UGS_IDLE    = 3'b000,
        UGS_SUSP    = 3'b001,
        UGS_RESUME  = 3'b010,
        UGS_EOP_SE0 = 3'b011,
        UGS_EOP_J   = 3'b100
    } ugs_state_t;

endpackage

// >>> ugs_sync.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------------------
module ugs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q; // First stage, read only by the second

    // ------------------------------------------------------------------------
    // Both stages; nothing else may look at meta_q
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// >>> ugs_checker.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Port-level checker for the suspend/resume block
// ----------------------------------------------------------------------------
module ugs_checker
    import ugs_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        irq_o,
    // Port pins and schedule enables
    input wire logic [1:0]  dp_i,
    input wire logic [1:0]  dm_i,
    input wire logic [1:0]  dp_o,
    input wire logic [1:0]  dm_o,
    input wire logic [1:0]  oe_n_o,
    input wire logic        sched_en_o,
    input wire logic        sof_en_o
);
    // Mirror of the suspend bit plus EOP phase lengths
    typedef struct packed {
        logic       susp;
        logic [8:0] se0_cnt;
        logic [8:0] j_cnt;
    } ugs_chk_t;
    ugs_chk_t q, d;
    logic wr_cmd, wr_fr0, drv_k, drv_se0, drv_j, k_in;
    // A command write lands at the edge where ack is sampled
    assign wr_cmd  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
                   & (wb_adr_i == UGS_CMD_OFF);
    assign wr_fr0  = wr_cmd & ~wb_dat_i[UGS_CMD_FORCE_RES];
    assign drv_k   = (oe_n_o == 2'h0) && (dp_o == 2'h0) && (dm_o == 2'h3);
    assign drv_se0 = (oe_n_o == 2'h0) && (dp_o == 2'h0) && (dm_o == 2'h0);
    assign drv_j   = (oe_n_o == 2'h0) && (dp_o == 2'h3) && (dm_o == 2'h0);
    // K seen on port 0 only while the host has released the line
    assign k_in    = (oe_n_o == 2'h3) && !dp_i[0] && dm_i[0];
    // Next state of the helper counters
    always_comb begin
        d = q;
        if (wr_cmd) begin
            d.susp = wb_dat_i[UGS_CMD_SUSPEND];
        end
        d.se0_cnt = drv_se0 ? q.se0_cnt + 9'h1 : 9'h0;
        d.j_cnt   = drv_j ? q.j_cnt + 9'h1 : 9'h0;
    end
    // Register the helper state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_force_drives_k: assert property (wr_cmd && wb_dat_i[UGS_CMD_FORCE_RES]
        && oe_n_o == 2'h3 |-> ##[1:3] drv_k) else $error("force write gave no resume");
    a_wake_drives_k: assert property (q.susp && k_in [*2] |-> ##[1:4] drv_k)
        else $error("resume event while suspended not answered");
    a_k_held_flag: assert property ($fell(drv_k) |-> $past(wr_fr0) || $past(wr_fr0, 2)
        || $past(wr_fr0, 3)) else $error("resume dropped without software clear");
    a_k_then_se0: assert property ($fell(drv_k) |-> drv_se0)
        else $error("resume not followed by SE0");
    a_se0_then_j: assert property ($fell(drv_se0) |-> drv_j)
        else $error("SE0 not followed by J");
    a_se0_length: assert property ($fell(drv_se0) |-> q.se0_cnt == UGS_SE0_CYC)
        else $error("EOP SE0 length wrong");
    a_j_length: assert property ($fell(drv_j) |-> q.j_cnt == UGS_J_CYC && oe_n_o == 2'h3)
        else $error("EOP J length or release wrong");
    a_susp_no_sched: assert property (q.susp && $past(q.susp) |-> !sched_en_o)
        else $error("schedule enabled in suspend");
    a_sof_with_sched: assert property (sof_en_o == sched_en_o)
        else $error("SOF enable split");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    c_resume: cover property (drv_k);
    c_eop_done: cover property ($fell(drv_j));
    c_wake: cover property (q.susp && k_in);
    c_irq: cover property (irq_o);
endmodule

bind ugs_top ugs_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .irq_o, .dp_i, .dm_i, .dp_o, .dm_o, .oe_n_o,
    .sched_en_o, .sof_en_o);

// >>> ugs_dev_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Downstream device: one full-speed device on port 0, port 1 empty
// ----------------------------------------------------------------------------
module ugs_dev_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Bench command: start remote wake K
    input  wire logic       wake_i,
    // Bench command: pull the device off port 0
    input  wire logic       unplug_i,
    // Host side of the lines
    input  wire logic [1:0] host_dp_i,
    input  wire logic [1:0] host_dm_i,
    input  wire logic [1:0] host_oe_n_i,
    // Line levels seen by the host
    output logic      [1:0] conn_o,
    output logic      [1:0] dp_o,
    output logic      [1:0] dm_o
);
    logic k_q; // Device is signalling K
    // Device keeps K until the host takes the line over
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            k_q <= 1'b0;
        end else if (wake_i) begin
            k_q <= 1'b1;
        end else if (host_oe_n_i != 2'h3) begin
            k_q <= 1'b0;
        end
    end
    // Port 1 stays empty; unplugging port 0 is a resume event for a suspended host
    assign conn_o = {1'b0, ~unplug_i};
    // Released line: J on the pulled-up port, SE0 on the empty one via pull-downs
    assign dp_o = (~host_oe_n_i & host_dp_i) | (host_oe_n_i & conn_o & {2{~k_q}});
    assign dm_o = (~host_oe_n_i & host_dm_i) | (host_oe_n_i & conn_o & {2{k_q}});
endmodule

// >>> ugs_top_tb.sv
`timescale 1ns/1ns
module ugs_top_tb
    import ugs_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, r;
    logic        ack, irq, busy = 1'b0, done = 1'b0, wake = 1'b0, sched, sof, unplug = 1'b0;
    logic [1:0]  conn, dpi, dmi, dpo, dmo, oen;
    int          err_count = 0, samples_checked = 0, cycles = 0, n;
    always #4 clk_i = ~clk_i;
    ugs_top uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .conn_i(conn), .dp_i(dpi), .dm_i(dmi), .dp_o(dpo), .dm_o(dmo), .oe_n_o(oen),
        .txn_busy_i(busy), .txn_done_i(done), .sched_en_o(sched), .sof_en_o(sof));
    ugs_dev_model dev (.clk_i, .rst_i, .wake_i(wake), .host_dp_i(dpo), .host_dm_i(dmo),
        .host_oe_n_i(oen), .unplug_i(unplug), .conn_o(conn), .dp_o(dpi), .dm_o(dmi));
    task finish_test();
        if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard: the whole run needs about a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end
    task chk(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) begin
            err_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    // One classic cycle; waits for ack, data taken at the same edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        {cyc, stb} <= 2'b00;
        chk(n < 50, "no ack");
    endtask
    task pulse_done();
        @(posedge clk_i) done <= 1'b1;
        @(posedge clk_i) done <= 1'b0;
    endtask
    task t_reset();
        wb(0, UGS_STS_OFF, 0); chk(r[UGS_STS_HALTED] === 1'b1, "not halted");
        wb(0, 8'h20, 0); chk(r === 32'h0, "unmapped read"); 
        chk(oen === 2'h3 && sof === 1'b0, "ports not idle");
    endtask
    task t_run_stop();
        busy <= 1'b1;
        wb(1, UGS_CMD_OFF, 32'h1); wb(0, UGS_STS_OFF, 0);
        chk(sched === 1'b1 && r[UGS_STS_HALTED] === 1'b0, "not running");
        chk(sof === 1'b1, "no frame starts while running");
        wb(1, UGS_CMD_OFF, 32'h0); wb(0, UGS_STS_OFF, 0);
        chk(r[UGS_STS_HALTED] === 1'b0, "halted mid transaction");
        busy <= 1'b0; pulse_done(); wb(0, UGS_STS_OFF, 0);
        chk(r[UGS_STS_HALTED] === 1'b1, "no halt after transaction");
        wb(0, UGS_ISTAT_OFF, 0); chk(r[UGS_EV_HALTED] === 1'b1, "no halt event");
        wb(1, UGS_ISTAT_OFF, 32'h7);
    endtask
    task t_step();
        wb(1, UGS_CMD_OFF, 32'h21); pulse_done(); wb(0, UGS_CMD_OFF, 0);
        chk(r[5:0] === 6'h20 && sched === 1'b0, "step kept running");
        wb(1, UGS_CMD_OFF, 32'h0);
    endtask
    // Software ends resume; flag must read one until the EOP is over
    task end_resume(input logic [31:0] d);
        // Clear a stale EOP event so the check below sees this EOP only
        wb(1, UGS_ISTAT_OFF, 32'h2);
        wb(1, UGS_CMD_OFF, d); wb(0, UGS_CMD_OFF, 0);
        chk(r[UGS_CMD_FORCE_RES] === 1'b1, "flag dropped early");
        n = 0;
        while (oen !== 2'h3 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 1000, "EOP never ended");
        wb(0, UGS_CMD_OFF, 0); chk(r[UGS_CMD_FORCE_RES] === 1'b0, "flag stuck");
        wb(0, UGS_ISTAT_OFF, 0); chk(r[UGS_EV_EOP_DONE] === 1'b1, "no EOP event");
    endtask
    task t_wake();
        wb(1, UGS_IMASK_OFF, 32'h1); wb(1, UGS_CMD_OFF, 32'h08); wb(0, UGS_STS_OFF, 0);
        chk(r[UGS_STS_SUSPENDED] === 1'b1 && sched === 1'b0, "not suspended");
        chk(oen === 2'h3 && sof === 1'b0 && irq === 1'b0, "suspend not quiet");
        @(posedge clk_i) wake <= 1'b1;
        @(posedge clk_i) wake <= 1'b0;
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        chk(irq === 1'b1, "no wake interrupt");
        chk(oen === 2'h0 && dpo === 2'h0 && dmo === 2'h3, "no resume K");
        wb(0, UGS_CMD_OFF, 0); chk(r[UGS_CMD_FORCE_RES] === 1'b1, "flag not set");
        wb(1, UGS_ISTAT_OFF, 32'h1); wb(0, UGS_ISTAT_OFF, 0);
        chk(irq === 1'b0, "irq after clear");
        end_resume(32'h08);
        wb(0, UGS_STS_OFF, 0); chk(r[UGS_STS_SUSPENDED] === 1'b1, "left suspend");
        wb(1, UGS_CMD_OFF, 32'h0); wb(0, UGS_STS_OFF, 0);
        chk(r[UGS_STS_SUSPENDED] === 1'b0, "still suspended");
    endtask
    task t_force();
        wb(1, UGS_IMASK_OFF, 32'h0); wb(1, UGS_CMD_OFF, 32'h10);
        repeat (100) @(posedge clk_i); // Short hold: resume length is software timed
        chk(oen === 2'h0 && dpo === 2'h0 && dmo === 2'h3, "forced resume missing");
        end_resume(32'h0);
        chk(irq === 1'b0, "masked event raised irq");
    endtask
    // Disconnect while suspended is a resume event as well
    task t_unplug();
        wb(1, UGS_IMASK_OFF, 32'h1); wb(1, UGS_CMD_OFF, 32'h08);
        @(posedge clk_i) unplug <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        chk(irq === 1'b1 && oen === 2'h0 && dmo === 2'h3, "no resume on disconnect");
        wb(1, UGS_ISTAT_OFF, 32'h1);
        end_resume(32'h0);
        wb(0, UGS_STS_OFF, 0); chk(r[UGS_STS_SUSPENDED] === 1'b0, "suspend kept");
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_run_stop();
        t_step();
        t_wake();
        t_force();
        t_unplug();
        finish_test();
    end
endmodule
